/* File: logic/spep_fifo.sv */
`default_nettype none
`include "spep_map.svh"
module spep_fifo #(
  parameter int WIDTH  = `SPEP_FIFO_WIDTH,
  parameter int DEPTH  = `SPEP_FIFO_DEPTH,
  parameter int ADDR_W = `SPEP_FIFO_ADDR_W
) (
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [WIDTH-1:0]  in_data_in,
  input  wire logic              in_valid_in,
  output logic                   in_ready_out,
  output logic [WIDTH-1:0]       out_data_out,
  output logic                   out_valid_out,
  input  wire logic              out_ready_in
);
  import spep_pkg::*;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [ADDR_W:0]  wr_ptr;
  logic [ADDR_W:0]  rd_ptr;
  wire              do_push;
  wire              do_pop;
  wire              is_full;
  wire              is_empty;

  // Extra pointer bit tells full from empty
  assign is_empty      = (wr_ptr == rd_ptr);
  assign is_full       = (wr_ptr[ADDR_W] != rd_ptr[ADDR_W]) && (wr_ptr[ADDR_W-1:0] == rd_ptr[ADDR_W-1:0]);
  assign do_push       = in_valid_in && !is_full;
  assign do_pop        = out_ready_in && !is_empty;
  assign in_ready_out  = !is_full;
  assign out_valid_out = !is_empty;
  assign out_data_out  = mem[rd_ptr[ADDR_W-1:0]];

  // Pointers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage needs no reset; valid gates every read
  always_ff @(posedge clk_in) begin
    if (do_push) mem[wr_ptr[ADDR_W-1:0]] <= in_data_in;
  end
endmodule
`default_nettype wire

/* File: logic/spep_map.svh */
`ifndef SPEP_MAP_SVH
`define SPEP_MAP_SVH
// ----------------------------------------
// Frame constants
// ----------------------------------------
`define SPEP_PREAMBLE_FIRST   8'hAA
`define SPEP_PREAMBLE_SECOND  8'h55
`define SPEP_LAST_BIT         3'h7
`define SPEP_BYTE_PAYLOAD     2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define SPEP_CLK_MHZ          40
`define SPEP_SCK_MAX_MHZ      5
// Least serial clock period in system clocks, rounded up
`define SPEP_SCK_MIN_CYCLES   ((`SPEP_CLK_MHZ + `SPEP_SCK_MAX_MHZ - 1) / `SPEP_SCK_MAX_MHZ)
// ----------------------------------------
// Buffer shape
// ----------------------------------------
`define SPEP_FIFO_WIDTH       8
`define SPEP_FIFO_DEPTH       8
`define SPEP_FIFO_ADDR_W      3
// ----------------------------------------
// Input synchroniser bit positions
// ----------------------------------------
`define SPEP_IN_RST_PIN       0
`define SPEP_IN_POR_DONE      1
`define SPEP_IN_SCK           2
`define SPEP_IN_MOSI          3
`define SPEP_IN_SS_N          4
`define SPEP_IN_COUNT         5
// Idle pin levels: reset pin and select high, others low
`define SPEP_IN_IDLE          5'h11
`endif

/* File: logic/spep_pkg.sv */
`default_nettype none
package spep_pkg;
  // Programming session state
  typedef enum logic [1:0] {
    SPEP_OFF    = 2'b00,
    SPEP_ACTIVE = 2'b01,
    SPEP_SPENT  = 2'b10
  } spep_mode_e;
  typedef logic [7:0] spep_byte_t;
endpackage
`default_nettype wire

/* File: logic/spep_port.sv */
// How it works
// - Programmer is always bus master; this port only ever answers as slave.
// - Four wires: clock, data in, data out, active-low select; full duplex.
// - Only clock mode zero, serial clock no faster than 5 MHz.
// - Programming logic runs on the system clock and samples the serial clock through synchronisers.
// - Programming mode entered and held only while reset pin is low.
// - With reset pin reused as I/O, it still acts as reset at power-up.
// - After power-on entry, mode holds until reset pin goes high.
// - With reset reused, no second session until power is cycled.
// - Entry fuse set: entry in any reset; cleared: only at power-on reset.
// - Reset pin tied low forces programming entry whatever the fuses say.
// - Select low frames a command; command completes only on select rising.
// - Command bytes arrive on master-out; answers leave on master-in.
// - Packets start with AAH then 55H; without it nothing is acted on.
`default_nettype none
`include "spep_map.svh"
module spep_port (
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  input  wire logic               rst_pin_n_in,
  input  wire logic               por_done_in,
  input  wire logic               reset_disabled_in,
  input  wire logic               programming_entry_fuse_in,
  input  wire logic               sck_in,
  input  wire logic               mosi_in,
  input  wire logic               ss_n_in,
  input  wire spep_pkg::spep_byte_t tx_byte_in,
  input  wire logic               rx_ready_in,
  output logic                    miso_out,
  output logic                    miso_oe_n_out,
  output logic                    in_system_programming_mode_out,
  output spep_pkg::spep_byte_t    rx_byte_out,
  output logic                    rx_valid_out,
  output logic                    frame_done_out,
  output logic                    frame_abort_out,
  output logic                    rx_overrun_out
);
  import spep_pkg::*;
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [`SPEP_IN_COUNT-1:0] meta;
  logic [`SPEP_IN_COUNT-1:0] sync;
  logic                      sck_prev;
  logic                      ss_prev;
  wire  [`SPEP_IN_COUNT-1:0] raw_in;

  assign raw_in = {ss_n_in, mosi_in, sck_in, por_done_in, rst_pin_n_in};

  // Two stages; only the second stage is looked at
  // Reset to idle levels, else a low pin and busy POR fake an entry and a select edge
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta     <= `SPEP_IN_IDLE;
      sync     <= `SPEP_IN_IDLE;
      sck_prev <= 1'b0;
      ss_prev  <= 1'b1;
    end else begin
      meta     <= raw_in;
      sync     <= meta;
      sck_prev <= sync[`SPEP_IN_SCK];
      ss_prev  <= sync[`SPEP_IN_SS_N];
    end
  end

  // Edge finding on the sampled serial clock and select
  wire pin_low  = !sync[`SPEP_IN_RST_PIN];
  wire por_busy = !sync[`SPEP_IN_POR_DONE];
  wire sck_s    = sync[`SPEP_IN_SCK];
  wire mosi_s   = sync[`SPEP_IN_MOSI];
  wire ss_s     = sync[`SPEP_IN_SS_N];
  wire sck_rise = sck_s && !sck_prev;
  wire sck_fall = !sck_s && sck_prev;
  wire ss_rise  = ss_s && !ss_prev;
  wire ss_fall  = !ss_s && ss_prev;
  // ----------------------------------------
  // Mode entry and exit
  // ----------------------------------------
  spep_mode_e mode;
  spep_mode_e next_mode;
  wire        entry_ok;

  // Reused reset pin only counts during power-up; tied-low pin wins at POR
  assign entry_ok = pin_low && (por_busy || (programming_entry_fuse_in && !reset_disabled_in));

  always_comb begin
    next_mode = mode;
    case (mode)
      SPEP_OFF: begin
        if (entry_ok) next_mode = SPEP_ACTIVE;
      end
      SPEP_ACTIVE: begin
        // Held while the pin stays low, even after POR
        if (!pin_low) next_mode = reset_disabled_in ? SPEP_SPENT : SPEP_OFF;
      end
      SPEP_SPENT: begin
        next_mode = SPEP_SPENT;
      end
      default: begin
        next_mode = SPEP_OFF;
      end
    endcase
  end

  // Only a power cycle (block reset) leaves the spent state
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) mode <= SPEP_OFF;
    else mode <= next_mode;
  end
  // ----------------------------------------
  // Serial shifter
  // ----------------------------------------
  logic [2:0]  bit_cnt;
  logic [1:0]  byte_idx;
  logic [6:0]  rx_shift;
  logic        pre_first;
  logic        pre_ok;
  logic [7:0]  tx_shift;
  logic        load_pend;
  logic [7:0]  next_tx;
  wire         active    = (mode == SPEP_ACTIVE);
  wire         selected  = active && !ss_s;
  wire         byte_done = selected && sck_rise && (bit_cnt == `SPEP_LAST_BIT);
  wire [7:0]   rx_word   = {rx_shift, mosi_s};
  wire         push      = byte_done && pre_ok;
  wire         fifo_ready;

  // Counters and preamble tracker cleared whenever not selected
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !selected) begin
      bit_cnt   <= 3'h0;
      byte_idx  <= 2'h0;
      pre_first <= 1'b0;
      pre_ok    <= 1'b0;
    end else begin
      if (sck_rise) bit_cnt <= bit_cnt + 3'h1;
      if (byte_done && byte_idx != `SPEP_BYTE_PAYLOAD) byte_idx <= byte_idx + 2'h1;
      if (byte_done && byte_idx == 2'h0) pre_first <= (rx_word == `SPEP_PREAMBLE_FIRST);
      if (byte_done && byte_idx == 2'h1) pre_ok <= pre_first && (rx_word == `SPEP_PREAMBLE_SECOND);
    end
  end

  // Mode 0: sample on rising edge
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) rx_shift <= 7'h00;
    else if (selected && sck_rise) rx_shift <= rx_word[6:0];
  end

  // Next outgoing bits: load at frame start and after each byte, shift on falling edge
  always_comb begin
    next_tx = tx_shift;
    if (active && ss_fall) next_tx = tx_byte_in;
    else if (selected && sck_fall) next_tx = load_pend ? tx_byte_in : {tx_shift[6:0], 1'b0};
  end

  // MISO taken from the next value to win a cycle of the half period
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tx_shift      <= 8'h00;
      load_pend     <= 1'b0;
      miso_out      <= 1'b0;
      miso_oe_n_out <= 1'b1;
    end else begin
      tx_shift      <= next_tx;
      // A pending load never survives into the next frame
      load_pend     <= selected && (byte_done || (load_pend && !sck_fall));
      miso_out      <= next_tx[7];
      miso_oe_n_out <= !(next_mode == SPEP_ACTIVE && !ss_s);
    end
  end
  // ----------------------------------------
  // Frame outcome and status
  // ----------------------------------------
  wire frame_end = active && ss_rise;

  // Command counts only when select rises on a byte boundary after the preamble
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      frame_done_out                 <= 1'b0;
      frame_abort_out                <= 1'b0;
      rx_overrun_out                 <= 1'b0;
      in_system_programming_mode_out <= 1'b0;
    end else begin
      frame_done_out                 <= frame_end && pre_ok && (bit_cnt == 3'h0);
      frame_abort_out                <= frame_end && !(pre_ok && (bit_cnt == 3'h0));
      // Set wins over the clear at a new frame
      rx_overrun_out                 <= (push && !fifo_ready) || (rx_overrun_out && !(active && ss_fall));
      in_system_programming_mode_out <= (next_mode == SPEP_ACTIVE);
    end
  end

  // The link cannot be paused, so a full buffer drops the byte and flags it
  spep_fifo #(
    .WIDTH  (`SPEP_FIFO_WIDTH),
    .DEPTH  (`SPEP_FIFO_DEPTH),
    .ADDR_W (`SPEP_FIFO_ADDR_W)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .in_data_in    (rx_word),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .out_data_out  (rx_byte_out),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in)
  );
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_mode_needs_pin: assert property (active && !pin_low |=> !active)
    else $error("mode held with reset pin high");
  chk_entry_gate: assert property ($rose(active) |-> $past(por_busy || (programming_entry_fuse_in && !reset_disabled_in)))
    else $error("entry outside allowed reset");
  chk_spent_stays: assert property (mode == SPEP_SPENT |=> mode == SPEP_SPENT [*4])
    else $error("second session after spent");
  chk_reused_pin_por: assert property (reset_disabled_in && !por_busy && mode == SPEP_OFF |=> mode != SPEP_ACTIVE)
    else $error("reused pin entered after POR");
  chk_counters_clear: assert property (!selected |=> bit_cnt == 3'h0 && byte_idx == 2'h0 && !pre_ok)
    else $error("counters not cleared");
  chk_push_preamble: assert property (u_fifo.do_push |-> pre_ok && byte_idx == `SPEP_BYTE_PAYLOAD)
    else $error("byte stored without preamble");
  chk_frame_done: assert property (frame_end && pre_ok && bit_cnt == 3'h0 |=> frame_done_out ##1 !frame_done_out)
    else $error("frame completion pulse wrong");
  chk_miso_drive: assert property (!miso_oe_n_out |-> $past(next_mode == SPEP_ACTIVE && !ss_s))
    else $error("miso driven when not selected");
  chk_sck_spacing: assert property (sck_rise |=> !sck_rise [*3])
    else $error("serial clock too fast");

  cov_entry:  cover property ($rose(active));
  cov_push:   cover property (u_fifo.do_push);
  cov_done:   cover property (frame_done_out);
  cov_spent:  cover property (mode == SPEP_SPENT);
endmodule
`default_nettype wire

/* File: verification/spep_port_tb.sv */
`default_nettype none
module spep_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spep_pkg::*;

  logic       clk_in, reset_n, rst_pin_n, por_done, reset_disabled, entry_fuse;
  logic       sck, mosi, ss_n, rx_ready, miso, miso_oe_n, mode, rx_valid;
  logic       frame_done, frame_abort, rx_overrun, live;
  spep_byte_t tx_byte, rx_byte;
  int         num_errors, cmp_count, cycles;
  logic [7:0] n_done, n_abort;
  logic [4:0] rows [6];

  spep_port spep_port_inst (.clk_in(clk_in), .reset_n_in(reset_n), .rst_pin_n_in(rst_pin_n),
    .por_done_in(por_done), .reset_disabled_in(reset_disabled), .programming_entry_fuse_in(entry_fuse),
    .sck_in(sck), .mosi_in(mosi), .ss_n_in(ss_n), .tx_byte_in(tx_byte), .rx_ready_in(rx_ready),
    .miso_out(miso), .miso_oe_n_out(miso_oe_n), .in_system_programming_mode_out(mode),
    .rx_byte_out(rx_byte), .rx_valid_out(rx_valid), .frame_done_out(frame_done),
    .frame_abort_out(frame_abort), .rx_overrun_out(rx_overrun));
  spep_prog spep_prog_inst (.clk_in(clk_in), .miso_in(miso), .miso_oe_n_in(miso_oe_n),
    .sck_out(sck), .mosi_out(mosi), .ss_n_out(ss_n));

  // ----------------------------------------
  // Clock, pulse counters, hang guard
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Ceiling well above the roughly 1800 cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (frame_done === 1'b1) n_done++;
    if (frame_abort === 1'b1) n_abort++;
    if (cycles == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Compares and drivers
  // ----------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Power cycle with reset pin, POR and fuses set first
  task automatic power(input logic pin, input logic por, input logic dis, input logic fuse);
    reset_n = 1'b0;
    rst_pin_n = pin;
    por_done = por;
    reset_disabled = dis;
    entry_fuse = fuse;
    repeat (5) @(posedge clk_in);
    #2 reset_n = 1'b1;
    settle();
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_in);
    #2;
  endtask
  // One byte or part of one; answer checked only when a reply is due
  task automatic send(input spep_byte_t b, input int n);
    spep_byte_t r;
    spep_prog_inst.xfer(b, n, r);
    if (live) chk_bit("oe_n", 1'b0, miso_oe_n);
    if (live && n == 8) chk_byte("miso", tx_byte, r);
  endtask
  task automatic pop(input spep_byte_t exp);
    chk_bit("valid", 1'b1, rx_valid);
    chk_byte("rx", exp, rx_byte);
    @(posedge clk_in);
    #2 rx_ready = 1'b1;
    @(posedge clk_in);
    #2 rx_ready = 1'b0;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    rst_pin_n = 1'b1;
    por_done = 1'b0;
    reset_disabled = 1'b0;
    entry_fuse = 1'b0;
    rx_ready = 1'b0;
    live = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    n_done = 8'h00;
    n_abort = 8'h00;
    tx_byte = 8'h5A;
    // Rows: pin, POR done, reset reused, fuse, expected mode
    rows = '{5'b00001, 5'b01011, 5'b01000, 5'b10000, 5'b01110, 5'b00101};
    foreach (rows[k]) begin
      power(rows[k][4], rows[k][3], rows[k][2], rows[k][1]);
      chk_bit("mode", rows[k][0], mode);
    end
    // Good packet entered at POR; POR ends mid-frame
    power(1'b0, 1'b0, 1'b0, 1'b0);
    live = 1'b1;
    spep_prog_inst.select(1'b1);
    send(8'hAA, 8);
    por_done = 1'b1;
    send(8'h55, 8);
    send(8'h3C, 8);
    send(8'hC3, 8);
    spep_prog_inst.select(1'b0);
    settle();
    chk_byte("done", 8'h01, n_done);
    chk_bit("mode", 1'b1, mode);
    pop(8'h3C);
    pop(8'hC3);
    rst_pin_n = 1'b1;
    settle();
    chk_bit("mode", 1'b0, mode);
    rst_pin_n = 1'b0;
    settle();
    chk_bit("mode", 1'b0, mode);
    entry_fuse = 1'b1;
    rst_pin_n = 1'b1;
    settle();
    rst_pin_n = 1'b0;
    settle();
    chk_bit("mode", 1'b1, mode);
    // Broken preamble, then a partial byte: both discarded
    tx_byte = 8'hA5;
    spep_prog_inst.select(1'b1);
    send(8'hAA, 8);
    send(8'h54, 8);
    send(8'h11, 8);
    spep_prog_inst.select(1'b0);
    spep_prog_inst.select(1'b1);
    send(8'hAA, 8);
    send(8'h55, 8);
    send(8'hF0, 4);
    spep_prog_inst.select(1'b0);
    settle();
    chk_byte("abort", 8'h02, n_abort);
    chk_bit("valid", 1'b0, rx_valid);
    // Nine payload bytes into eight places while the consumer stalls
    tx_byte = 8'h96;
    spep_prog_inst.select(1'b1);
    send(8'hAA, 8);
    send(8'h55, 8);
    for (int i = 0; i < 9; i++) send(8'h10 + 8'(i), 8);
    spep_prog_inst.select(1'b0);
    settle();
    chk_bit("overrun", 1'b1, rx_overrun);
    for (int i = 0; i < 8; i++) pop(8'h10 + 8'(i));
    chk_bit("valid", 1'b0, rx_valid);
    // A new frame clears the sticky overrun
    spep_prog_inst.select(1'b1);
    chk_bit("overrun", 1'b0, rx_overrun);
    spep_prog_inst.select(1'b0);
    // Reused reset pin: one session a power cycle
    power(1'b0, 1'b0, 1'b1, 1'b0);
    chk_bit("mode", 1'b1, mode);
    rst_pin_n = 1'b1;
    settle();
    rst_pin_n = 1'b0;
    settle();
    chk_bit("mode", 1'b0, mode);
    // Outside programming mode the port stays silent
    live = 1'b0;
    power(1'b1, 1'b1, 1'b0, 1'b0);
    spep_prog_inst.select(1'b1);
    send(8'hAA, 8);
    send(8'h55, 8);
    send(8'h77, 8);
    chk_bit("oe_n", 1'b1, miso_oe_n);
    spep_prog_inst.select(1'b0);
    settle();
    chk_bit("valid", 1'b0, rx_valid);
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: verification/spep_prog.sv */
`default_nettype none
module spep_prog (
  input  wire logic clk_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_n_in,
  output logic      sck_out,
  output logic      mosi_out,
  output logic      ss_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import spep_pkg::*;

  // ----------------------------------------
  // Idle lines
  // ----------------------------------------
  // Select driven high from the start, never floating
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    ss_n_out = 1'b1;
  end

  // Four system clocks a half period: 200 ns serial period
  task automatic half();
    repeat (4) @(posedge clk_in);
    #2;
  endtask

  // Master frames the packet with select
  task automatic select(input logic low);
    half();
    ss_n_out = ~low;
    if (!low) mosi_out = ~mosi_out; // No stale data once released
    half();
  endtask

  // Mode zero, MSB first, full duplex
  task automatic xfer(input spep_byte_t b, input int n, output spep_byte_t r);
    r = 8'hXX;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_out = b[i];
      half();
      sck_out = 1'b1;
      r[i] = miso_oe_n_in ? 1'bx : miso_in;
      half();
      sck_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire
